// *** core/hyst_threshold.sv ***
`timescale 1ns/1ns
`default_nettype none

module hyst_threshold #(
  parameter int W = 8
) (
  input wire logic [W-1:0] sample_i,
  input wire logic [W-1:0] rise_i,
  input wire logic [W-1:0] fall_i,
  input wire logic level_i,
  output logic level_o
);

  generate
    if (W < 1) begin : g_bad_width
      $error("hyst_threshold: width must be at least one");
    end
  endgenerate

  wire above_rise = sample_i > rise_i;
  wire below_rise = sample_i < rise_i;
  wire below_fall = sample_i < fall_i;
  // Hysteresis collapses onto the rising threshold when the band is empty
  wire no_band = fall_i >= rise_i;
  wire go_low = no_band ? below_rise : below_fall;

  assign level_o = above_rise ? 1'b1 : (go_low ? 1'b0 : level_i);

endmodule

`default_nettype wire

// *** core/light_ctrl_consts.svh ***
`ifndef LIGHT_CTRL_CONSTS_SVH
`define LIGHT_CTRL_CONSTS_SVH

// Register offsets
`define FUNC_REG_OFS 8'h12
`define SAMPLE_REG_OFS 8'h13
`define RISE_REG_OFS 8'h14
`define FALL_REG_OFS 8'h15

// Converter function register fields
`define FUNC_CMP_BIT 7
`define FUNC_EVENT_BIT 6
`define FUNC_SATEN_BIT 5
`define FUNC_OF_BIT 4
`define FUNC_UF_BIT 3
`define FUNC_CLEAR_BIT 2
`define FUNC_AUTO_BIT 1
`define FUNC_CONV_EN_BIT 0

// Reset values
`define SAMPLE_RESET 8'h00
`define RISE_RESET 8'h00
`define FALL_RESET 8'h00
`define READ_RESET 8'h00
// Sample resets to zero, which is already an underflow
`define UNDERFLOW_RESET 1'b1

// Saturation limits and full-scale code
`define OVERFLOW_LIMIT 8'hf8
`define UNDERFLOW_LIMIT 8'h08
`define FULL_SCALE_CODE 8'hff

`endif

// *** core/light_ctrl_pkg.sv ***
package light_ctrl_pkg;

  // One register access as handed on by the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One converter result
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } conv_sample_t;

  // Brightness choice for the first bank
  typedef enum logic [0:0] {
    LEVEL_START = 1'b0,
    LEVEL_TARGET = 1'b1
  } bank_level_t;

endpackage

// *** core/light_threshold_ctrl.sv ***
// Behaviour
// [R1] Compare state goes high above rising threshold, low below falling threshold, else holds.
// [R2] Event flag sets whenever the compare state changes either way.
// [R3] Event flag clears on a read of the function register or a clear write.
// [R4] With saturation enable set, overflow or underflow also sets the event flag.
// [R5] Overflow flag is one whenever the sample exceeds f8.
// [R6] Underflow flag is one whenever the sample is below 08.
// [R7] Writing one to the clear bit clears the event flag; bit self-clears, reads zero.
// [R8] With auto mode, bank one goes target above rise, start below fall.
// [R9] With auto mode off, comparison is frozen; bank one ignores sample and thresholds.
// [R10] With converter enabled, every conversion result is stored as the sample.
// [R11] Auto on, converter off: comparison continues on host-written sample values.
// [R12] Converter on, auto off: samples stored, bank one does not respond.
// [R13] Both enables off: converter off, bank one never changes with light.
// [R14] In auto mode with sample inside the band inclusive, bank one holds.
// [R15] Falling threshold not below rising: only the rising threshold decides; equal holds.
// [R16] Rising and falling thresholds are separate 8-bit writable registers after the sample.
// [R17] Sample is an 8-bit unsigned fraction of reference; ff is full scale.
// [R18] Compare and saturation flags re-evaluate on every sample update, any source.
// [R19] A saturation event is the rising of overflow or underflow flag.
`timescale 1ns/1ns
`default_nettype none
`include "light_ctrl_consts.svh"

module light_threshold_ctrl #(
  parameter int DATA_W = 8
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire light_ctrl_pkg::reg_req_t reg_req_i,
  input wire light_ctrl_pkg::conv_sample_t conv_sample_i,
  output logic [7:0] reg_rdata_o,
  output logic conv_enable_o,
  output light_ctrl_pkg::bank_level_t bank1_level_o,
  output logic light_event_o
);
  import light_ctrl_pkg::*;

  generate
    if (DATA_W != 8) begin : g_bad_width
      $error("light_threshold_ctrl: register map is fixed at 8-bit data");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0] light_sample_value;
  logic [7:0] rising_threshold;
  logic [7:0] falling_threshold;
  logic saturation_event_enable;
  logic auto_brightness_enable;
  logic converter_enable;
  logic conversion_overflow_flag;
  logic conversion_underflow_flag;
  logic light_event_flag;
  bank_level_t threshold_compare_state;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  wire sel_func = reg_req_i.addr == `FUNC_REG_OFS;
  wire sel_sample = reg_req_i.addr == `SAMPLE_REG_OFS;
  wire sel_rise = reg_req_i.addr == `RISE_REG_OFS;
  wire sel_fall = reg_req_i.addr == `FALL_REG_OFS;
  wire wr_func = reg_req_i.wr && sel_func;
  wire rd_func = reg_req_i.rd && sel_func;
  // Host write lands only while the converter is off; the converter owns it otherwise
  wire wr_sample = reg_req_i.wr && sel_sample && !converter_enable; // R11
  wire conv_store = converter_enable && conv_sample_i.valid; // R10 R12
  wire clear_write = wr_func && reg_req_i.wdata[`FUNC_CLEAR_BIT]; // R7

  ////////////////////////////////////////////////////////////////////////////
  // Sample path

  wire [7:0] next_sample = conv_store ? conv_sample_i.data :
                           (wr_sample ? reg_req_i.wdata : light_sample_value);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_sample_value <= `SAMPLE_RESET;
    end else begin
      light_sample_value <= next_sample; // R10 R11 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold and control registers

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rising_threshold <= `RISE_RESET;
      falling_threshold <= `FALL_RESET;
    end else begin
      if (reg_req_i.wr && sel_rise) begin
        rising_threshold <= reg_req_i.wdata; // R16
      end
      if (reg_req_i.wr && sel_fall) begin
        falling_threshold <= reg_req_i.wdata; // R16
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      saturation_event_enable <= 1'b0;
      auto_brightness_enable <= 1'b0;
      converter_enable <= 1'b0;
    end else if (wr_func) begin
      saturation_event_enable <= reg_req_i.wdata[`FUNC_SATEN_BIT];
      auto_brightness_enable <= reg_req_i.wdata[`FUNC_AUTO_BIT];
      converter_enable <= reg_req_i.wdata[`FUNC_CONV_EN_BIT]; // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison

  logic cmp_level;

  hyst_threshold #(
    .W(8)
  ) u_cmp (
    .sample_i(light_sample_value),
    .rise_i(rising_threshold),
    .fall_i(falling_threshold),
    .level_i(threshold_compare_state),
    .level_o(cmp_level)
  );

  // Frozen while auto mode is off, so threshold edits cannot move the bank
  bank_level_t next_cmp;
  assign next_cmp = auto_brightness_enable ? bank_level_t'(cmp_level) : threshold_compare_state; // R9 R12 R13
  wire cmp_change = next_cmp != threshold_compare_state;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      threshold_compare_state <= LEVEL_START;
    end else begin
      threshold_compare_state <= next_cmp; // R1 R8 R14 R15 R18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saturation and event flag

  wire next_of = light_sample_value > `OVERFLOW_LIMIT; // R5
  wire next_uf = light_sample_value < `UNDERFLOW_LIMIT; // R6
  wire sat_rise = (next_of && !conversion_overflow_flag) || (next_uf && !conversion_underflow_flag); // R19
  wire event_set = cmp_change || (saturation_event_enable && sat_rise); // R2 R4
  wire event_clear = rd_func || clear_write; // R3 R7

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conversion_overflow_flag <= 1'b0;
      conversion_underflow_flag <= `UNDERFLOW_RESET; // R6
    end else begin
      conversion_overflow_flag <= next_of; // R5 R18
      conversion_underflow_flag <= next_uf; // R6 R18
    end
  end

  // Set beats clear so an event landing on the clearing read is kept
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      light_event_flag <= 1'b0;
    end else if (event_set) begin
      light_event_flag <= 1'b1; // R2 R4
    end else if (event_clear) begin
      light_event_flag <= 1'b0; // R3 R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire [7:0] func_view = {threshold_compare_state, light_event_flag, saturation_event_enable,
                          conversion_overflow_flag, conversion_underflow_flag, 1'b0,
                          auto_brightness_enable, converter_enable}; // R7
  wire [7:0] read_mux = sel_func ? func_view :
                        sel_sample ? light_sample_value :
                        sel_rise ? rising_threshold :
                        sel_fall ? falling_threshold : 8'h00;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= `READ_RESET;
    end else if (reg_req_i.rd) begin
      reg_rdata_o <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Next values mirrored so the outputs line up with their registers
  wire next_conv_en = wr_func ? reg_req_i.wdata[`FUNC_CONV_EN_BIT] : converter_enable;
  wire next_event = event_set ? 1'b1 : (event_clear ? 1'b0 : light_event_flag);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      conv_enable_o <= 1'b0;
      bank1_level_o <= LEVEL_START;
      light_event_o <= 1'b0;
    end else begin
      conv_enable_o <= next_conv_en;
      bank1_level_o <= next_cmp; // R8
      light_event_o <= next_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  wire band_open = falling_threshold < rising_threshold;

  sequence s_host_sample;
    reg_req_i.wr && sel_sample && !converter_enable && !conv_store;
  endsequence

  sequence s_settle;
    auto_brightness_enable && $stable(light_sample_value) && $stable(rising_threshold);
  endsequence

  a_cmp_goes_high: assert property (auto_brightness_enable && light_sample_value > rising_threshold // R1
    |=> threshold_compare_state == LEVEL_TARGET) else $error("compare state not high above rise");
  a_cmp_goes_low: assert property (auto_brightness_enable && band_open // R1
    && light_sample_value < falling_threshold |=> threshold_compare_state == LEVEL_START)
    else $error("compare state not low below fall");
  a_event_on_change: assert property ($changed(threshold_compare_state) |-> light_event_flag) // R2
    else $error("compare change did not raise event");
  a_read_clears: assert property (rd_func && !event_set |=> !light_event_flag) // R3
    else $error("function read did not clear event");
  a_event_cause: assert property ($rose(light_event_flag) |-> $past(cmp_change) // R4
    || ($past(saturation_event_enable) && $past(sat_rise))) else $error("event set without cause");
  a_overflow_flag: assert property (light_sample_value > 8'hf8 [*2] |-> conversion_overflow_flag) // R5
    else $error("overflow flag missing");
  a_underflow_flag: assert property (light_sample_value < 8'h08 [*2] |-> conversion_underflow_flag) // R6
    else $error("underflow flag missing");
  a_clear_write: assert property (clear_write && !event_set |=> !light_event_flag) // R7
    else $error("clear write failed");
  a_clear_reads_zero: assert property (rd_func |=> reg_rdata_o[`FUNC_CLEAR_BIT] == 1'b0) // R7
    else $error("clear bit did not read zero");
  a_bank_follows: assert property (auto_brightness_enable && light_sample_value > rising_threshold // R8
    |=> bank1_level_o == LEVEL_TARGET) else $error("bank not at target above rise");
  a_auto_off_hold: assert property (!auto_brightness_enable |=> $stable(threshold_compare_state)) // R9 R13
    else $error("compare state moved with auto off");
  a_conv_store: assert property (conv_store |=> light_sample_value == $past(conv_sample_i.data)) // R10
    else $error("conversion result not stored");
  a_host_write: assert property (s_host_sample |=> light_sample_value == $past(reg_req_i.wdata)) // R11
    else $error("host sample write not stored");
  a_band_hold: assert property (auto_brightness_enable && band_open && light_sample_value >= falling_threshold // R14
    && light_sample_value <= rising_threshold |=> $stable(threshold_compare_state)) else $error("band not held");
  a_equal_rise: assert property (s_settle ##0 !band_open && light_sample_value == rising_threshold // R15
    |=> $stable(threshold_compare_state)) else $error("equal to rise changed state");
  a_sat_event: assert property (saturation_event_enable && sat_rise |=> light_event_flag [*1]) // R19
    else $error("saturation did not raise event");

endmodule

`default_nettype wire

// *** verification/conv_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// Converter stand-in: one result pulse per request while the device runs it
module conv_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic enable_i,
  input wire logic send_i,
  input wire logic [7:0] data_i,
  output light_ctrl_pkg::conv_sample_t sample_o
);
  import light_ctrl_pkg::*;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sample_o <= '0;
    end else if (send_i && enable_i) begin
      sample_o <= '{1'b1, data_i};
    end else begin
      // Data lines scramble between pulses so stale values never look valid
      sample_o <= '{1'b0, ~sample_o.data};
    end
  end
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  import light_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] smp;
    logic [2:0] flg;
  } row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  reg_req_t req = '0;
  conv_sample_t conv_s;
  logic send = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic [7:0] rdata;
  logic conv_en;
  bank_level_t bank;
  logic ev;
  logic [7:0] rd_v;
  logic prev_cmp = 1'b0;
  logic exp_ev;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] addrs [5] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h20};
  // Flags column: compare state, overflow, underflow
  row_t rows [14] = '{{8'h80, 8'h40, 8'h81, 3'b100}, {8'h80, 8'h40, 8'h80, 3'b100},
    {8'h80, 8'h40, 8'h40, 3'b100}, {8'h80, 8'h40, 8'h3f, 3'b000}, {8'h80, 8'h40, 8'h41, 3'b000},
    {8'h80, 8'h40, 8'hf9, 3'b110}, {8'h80, 8'h40, 8'hf8, 3'b100}, {8'h80, 8'h40, 8'h07, 3'b001},
    {8'h80, 8'h40, 8'h08, 3'b000}, {8'h50, 8'h60, 8'h55, 3'b100}, {8'h50, 8'h60, 8'h50, 3'b100},
    {8'h50, 8'h60, 8'h4f, 3'b000}, {8'h50, 8'h60, 8'h50, 3'b000}, {8'h50, 8'h60, 8'h51, 3'b100}};

  light_threshold_ctrl DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req), .conv_sample_i(conv_s),
    .reg_rdata_o(rdata), .conv_enable_o(conv_en), .bank1_level_o(bank), .light_event_o(ev));
  conv_model conv (.clk_i(clk_i), .resetn_i(resetn_i), .enable_i(conv_en), .send_i(send),
    .data_i(send_data), .sample_o(conv_s));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk_i);
    req <= '0;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk_i);
    req <= '0;
    @(negedge clk_i);
    d = rdata;
  endtask

  task automatic settle();
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic conv_send(input logic [7:0] d);
    @(posedge clk_i);
    send <= 1'b1;
    send_data <= d;
    @(posedge clk_i);
    send <= 1'b0;
    settle();
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    // Whole run is a few hundred cycles; this leaves a wide margin
    #2000000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check({5'h00, bank, ev, conv_en}, 8'h00, "outputs after reset");
    foreach (addrs[i]) begin
      reg_rd(addrs[i], rd_v);
      // Zero sample after reset already reads as underflow
      check(rd_v, (addrs[i] == 8'h12) ? 8'h08 : 8'h00, "reset or unmapped read");
    end
    reg_wr(8'h12, 8'h02);
    foreach (rows[i]) begin
      reg_wr(8'h14, rows[i].rise);
      reg_wr(8'h15, rows[i].fall);
      reg_wr(8'h13, rows[i].smp);
      settle();
      exp_ev = rows[i].flg[2] ^ prev_cmp;
      prev_cmp = rows[i].flg[2];
      check({7'h00, bank}, {7'h00, rows[i].flg[2]}, "bank level");
      check({7'h00, ev}, {7'h00, exp_ev}, "event output");
      reg_rd(8'h12, rd_v);
      check(rd_v, {rows[i].flg[2], exp_ev, 1'b0, rows[i].flg[1:0], 3'b010}, "function view");
      check({7'h00, ev}, 8'h00, "event after read");
    end
    // Saturation events with the compare frozen
    reg_wr(8'h12, 8'h20);
    reg_wr(8'h13, 8'h05);
    settle();
    check({6'h00, ev, bank}, 8'h03, "underflow event, bank held");
    reg_rd(8'h12, rd_v);
    check(rd_v, 8'he8, "saturation view");
    reg_wr(8'h13, 8'h04);
    settle();
    check({7'h00, ev}, 8'h00, "no repeat event");
    reg_wr(8'h12, 8'h00);
    reg_wr(8'h13, 8'h80);
    reg_wr(8'h13, 8'h03);
    settle();
    check({6'h00, ev, bank}, 8'h01, "saturation masked, bank held");
    reg_wr(8'h12, 8'h02);
    settle();
    check({6'h00, ev, bank}, 8'h02, "auto resumes");
    reg_wr(8'h12, 8'h06);
    @(negedge clk_i);
    check({7'h00, ev}, 8'h00, "clear write");
    reg_rd(8'h12, rd_v);
    check(rd_v, 8'h0a, "clear bit reads zero");
    // Converter path
    reg_wr(8'h12, 8'h01);
    @(negedge clk_i);
    check({7'h00, conv_en}, 8'h01, "converter enable");
    conv_send(8'hff);
    reg_rd(8'h13, rd_v);
    check(rd_v, 8'hff, "converted sample");
    check({7'h00, bank}, 8'h00, "bank ignores converter");
    reg_wr(8'h13, 8'h22);
    reg_rd(8'h13, rd_v);
    check(rd_v, 8'hff, "host write refused");
    conv_send(8'h30);
    reg_wr(8'h12, 8'h03);
    conv_send(8'hc0);
    check({6'h00, ev, bank}, 8'h03, "auto on converter");
    reg_wr(8'h12, 8'h00);
    @(negedge clk_i);
    check({7'h00, conv_en}, 8'h00, "converter off");
    // Mid-run reset must drop bank, event and rising threshold
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    @(negedge clk_i);
    check({5'h00, bank, ev, conv_en}, 8'h00, "outputs after mid-run reset");
    reg_rd(8'h14, rd_v);
    check(rd_v, 8'h00, "threshold after mid-run reset");
    finish_test();
  end
endmodule

`default_nettype wire
